// file: shared/lps_pkg.sv
// constants and the state type of the transceiver status and routing block
// assumes a 32-bit AXI4-Lite slave with register index = byte address / 4
package lps_pkg;

	localparam int ADDR_W = 12;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h50;
	localparam logic [7:0] IDX_FAULT = 8'h52;
	localparam logic [7:0] IDX_LIVE = 8'h53;
	localparam logic [7:0] IDX_TX_ROUTE = 8'h54;
	localparam logic [7:0] IDX_RX_ROUTE = 8'h55;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h58;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h59;

	// fault_flag_status bits
	localparam int BIT_OVERTEMP = 7;
	localparam int BIT_HF = 5;
	localparam int BIT_UV = 3;
	// line_live_status bits
	localparam int BIT_READY = 7;
	localparam int BIT_RX = 1;
	localparam int BIT_TX = 0;
	// route bits
	localparam int BIT_PORT_B = 1;
	localparam int BIT_UART = 0;
	// control bits
	localparam int BIT_OVERTEMP_IRQ_ENABLE = 7;
	localparam int BIT_FORCE = 4;
	localparam int BIT_LOW_VOLTAGE_SHUTDOWN_DISABLE = 3;
	// interrupt status / mask bits
	localparam int IRQ_OT = 2;
	localparam int IRQ_HF = 1;
	localparam int IRQ_UV = 0;

	// reset values and the control write mask
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [1:0] RST_ROUTE = 2'h0;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [2:0] RST_IRQ = 3'h0;
	localparam logic [7:0] CONTROL_WMASK = 8'h98;

	// line level on the uart and port b sides: low is dominant
	localparam logic LEVEL_RECESSIVE = 1'b1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [7:0] {
		SEL_NONE = 8'h01,
		SEL_CONTROL = 8'h02,
		SEL_FAULT = 8'h04,
		SEL_LIVE = 8'h08,
		SEL_TX_ROUTE = 8'h10,
		SEL_RX_ROUTE = 8'h20,
		SEL_IRQ_STATUS = 8'h40,
		SEL_IRQ_MASK = 8'h80
	} lps_sel_t;

	typedef struct packed {
		logic [7:0] fault;
		logic [1:0] tx_route;
		logic [1:0] rx_route;
		logic [7:0] control;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic lin_txd;
		logic uart_rxd;
		logic port_b_rxd;
		logic irq;
	} lps_state_t;

endpackage

// file: shared/lps_route_if.sv
// routing signals between the register core and the line multiplexer
// assumes both ends sit in the aclk domain
interface lps_route_if;
	logic tx_from_uart;
	logic tx_from_port_b;
	logic rx_to_uart;
	logic rx_to_port_b;
	logic force_dominant;
	logic shutdown;
	logic uart_txd;
	logic port_b_txd;
	logic rx_level;
	logic lin_txd_next;
	logic uart_rxd_next;
	logic port_b_rxd_next;

	modport core (
		output tx_from_uart, tx_from_port_b, rx_to_uart, rx_to_port_b,
		output force_dominant, shutdown, uart_txd, port_b_txd, rx_level,
		input lin_txd_next, uart_rxd_next, port_b_rxd_next
	);
	modport mux (
		input tx_from_uart, tx_from_port_b, rx_to_uart, rx_to_port_b,
		input force_dominant, shutdown, uart_txd, port_b_txd, rx_level,
		output lin_txd_next, uart_rxd_next, port_b_rxd_next
	);
endinterface

// file: design/lps_sync.sv
// two flip-flop synchroniser for asynchronous transceiver levels
// assumes aclk and a synchronous active-low reset; stages reset to the idle level given
module lps_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} lps_sync_state_t;

	lps_sync_state_t s_reg;
	lps_sync_state_t s_next;

	always_comb begin
		s_next.first = async_in;
		s_next.second = s_reg.first;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// idle level, so no false edge is seen after reset
			s_reg.first <= RST_VAL;
			s_reg.second <= RST_VAL;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.second;
endmodule

// file: design/lps_line_mux.sv
// transmit source selection and receive fan-out for the transceiver
// assumes line levels are low-dominant; outputs are registered by the core
module lps_line_mux (
	// routing bundle
	lps_route_if.mux rt
);
	logic selected;
	logic tx_dominant;

	always_comb begin
		if (rt.tx_from_uart) begin
			selected = rt.uart_txd;
		end else if (rt.tx_from_port_b) begin
			selected = rt.port_b_txd;
		end else begin
			selected = lps_pkg::LEVEL_RECESSIVE;
		end
		tx_dominant = (selected != lps_pkg::LEVEL_RECESSIVE) || rt.force_dominant;
		if (rt.shutdown) begin
			tx_dominant = 1'b0;
		end
		rt.lin_txd_next = tx_dominant ? ~lps_pkg::LEVEL_RECESSIVE : lps_pkg::LEVEL_RECESSIVE;
		rt.uart_rxd_next = rt.rx_to_uart ? rt.rx_level : lps_pkg::LEVEL_RECESSIVE;
		rt.port_b_rxd_next = rt.rx_to_port_b ? rt.rx_level : lps_pkg::LEVEL_RECESSIVE;
	end
endmodule

// file: design/lps_top.sv
// status flags, routing registers and AXI4-Lite slave of the on-chip LIN transceiver
// assumes transceiver detector levels are asynchronous; uart and port b are on aclk
//
// The AXI4-Lite interface to the registers was decided locally.
module lps_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [lps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [lps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// transceiver detectors, asynchronous
	input wire logic overtemp_detect,
	input wire logic hf_disturb_detect,
	input wire logic undervoltage_detect,
	input wire logic tx_ready,
	input wire logic lin_rxd,
	// transceiver transmit input, low is dominant
	output logic lin_txd,
	// uart module side, low is dominant
	input wire logic uart_txd,
	output logic uart_rxd,
	// port b gpio side, low is dominant
	input wire logic port_b_txd,
	output logic port_b_rxd,
	// interrupt
	output logic irq
);
	lps_pkg::lps_state_t s_reg;
	lps_pkg::lps_state_t s_next;

	logic [3:0] det_sync;
	logic rx_sync;
	logic ot_level;
	logic hf_level;
	logic uv_level;
	logic ready_level;
	logic rx_dominant;
	logic [7:0] fault_set;
	logic [7:0] fault_clr;
	logic [2:0] irq_set;
	logic [2:0] irq_rd_clr;
	logic wr_commit;
	logic [7:0] wbyte;
	logic [7:0] live_status;
	lps_pkg::lps_sel_t wr_sel;
	lps_pkg::lps_sel_t rd_sel;

	// detector order inside the flag loop: undervoltage, disturbance, overtemperature
	localparam int FLAG_N = 3;
	localparam int FLAG_POS [FLAG_N] = '{lps_pkg::BIT_UV, lps_pkg::BIT_HF, lps_pkg::BIT_OVERTEMP};
	localparam int FLAG_IRQ [FLAG_N] = '{lps_pkg::IRQ_UV, lps_pkg::IRQ_HF, lps_pkg::IRQ_OT};
	logic [FLAG_N-1:0] flag_level;
	logic [FLAG_N-1:0] flag_enable;
	logic [FLAG_N-1:0] flag_rise;

	lps_route_if rt ();

	// decode a byte address into a register select; nonzero upper bits miss
	function automatic lps_pkg::lps_sel_t decode(input logic [lps_pkg::ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[lps_pkg::ADDR_W-1:10] != '0) begin
			decode = lps_pkg::SEL_NONE;
		end else if (idx == lps_pkg::IDX_CONTROL) begin
			decode = lps_pkg::SEL_CONTROL;
		end else if (idx == lps_pkg::IDX_FAULT) begin
			decode = lps_pkg::SEL_FAULT;
		end else if (idx == lps_pkg::IDX_LIVE) begin
			decode = lps_pkg::SEL_LIVE;
		end else if (idx == lps_pkg::IDX_TX_ROUTE) begin
			decode = lps_pkg::SEL_TX_ROUTE;
		end else if (idx == lps_pkg::IDX_RX_ROUTE) begin
			decode = lps_pkg::SEL_RX_ROUTE;
		end else if (idx == lps_pkg::IDX_IRQ_STATUS) begin
			decode = lps_pkg::SEL_IRQ_STATUS;
		end else if (idx == lps_pkg::IDX_IRQ_MASK) begin
			decode = lps_pkg::SEL_IRQ_MASK;
		end else begin
			decode = lps_pkg::SEL_NONE;
		end
	endfunction

	lps_sync #(
		.WIDTH(4),
		.RST_VAL(4'h0)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({overtemp_detect, hf_disturb_detect, undervoltage_detect, tx_ready}),
		.sync_out(det_sync)
	);

	// the bus level resets recessive: a zero would read as a dominant bus after reset
	lps_sync #(
		.WIDTH(1),
		.RST_VAL(lps_pkg::LEVEL_RECESSIVE)
	) u_rx_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(lin_rxd),
		.sync_out(rx_sync)
	);

	assign ot_level = det_sync[3];
	assign hf_level = det_sync[2];
	assign uv_level = det_sync[1];
	assign ready_level = det_sync[0];
	assign rx_dominant = (rx_sync != lps_pkg::LEVEL_RECESSIVE);

	// route bundle to the multiplexer
	assign rt.tx_from_uart = s_reg.tx_route[lps_pkg::BIT_UART];
	assign rt.tx_from_port_b = s_reg.tx_route[lps_pkg::BIT_PORT_B];
	assign rt.rx_to_uart = s_reg.rx_route[lps_pkg::BIT_UART];
	assign rt.rx_to_port_b = s_reg.rx_route[lps_pkg::BIT_PORT_B];
	assign rt.force_dominant = s_reg.control[lps_pkg::BIT_FORCE];
	// same threshold gates shutdown unless disabled
	assign rt.shutdown = uv_level && !s_reg.control[lps_pkg::BIT_LOW_VOLTAGE_SHUTDOWN_DISABLE];
	assign rt.uart_txd = uart_txd;
	assign rt.port_b_txd = port_b_txd;
	assign rt.rx_level = rx_sync;

	lps_line_mux u_mux (
		.rt(rt)
	);

	assign flag_level = {ot_level, hf_level, uv_level};
	assign flag_enable = {s_reg.control[lps_pkg::BIT_OVERTEMP_IRQ_ENABLE], 2'h3};

	// an interrupt event is the cycle in which a flag first goes up
	for (genvar g = 0; g < FLAG_N; g++) begin : g_flag
		assign flag_rise[g] = flag_level[g] && flag_enable[g] && !s_reg.fault[FLAG_POS[g]];
	end

	assign wr_sel = decode(s_reg.aw_addr);
	assign rd_sel = decode(s_axi_araddr);
	assign wr_commit = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
	// only byte lane 0 carries register data; other lanes are dropped
	assign wbyte = s_reg.w_strb[0] ? s_reg.w_data[7:0] : 8'h00;

	always_comb begin
		live_status = 8'h00;
		live_status[lps_pkg::BIT_READY] = ready_level;
		live_status[lps_pkg::BIT_RX] = rx_dominant;
		live_status[lps_pkg::BIT_TX] = (s_reg.lin_txd != lps_pkg::LEVEL_RECESSIVE);
	end

	always_comb begin
		fault_set = 8'h00;
		// a flag keeps being set while its detector stays high
		for (int k = 0; k < FLAG_N; k++) begin
			fault_set[FLAG_POS[k]] = flag_level[k];
		end
		fault_clr = 8'h00;
		if (wr_commit && wr_sel == lps_pkg::SEL_FAULT) begin
			fault_clr = wbyte;
		end
		irq_set = 3'h0;
		// enable is sampled at event time; enabling later raises nothing
		for (int k = 0; k < FLAG_N; k++) begin
			irq_set[FLAG_IRQ[k]] = flag_rise[k];
		end
		irq_rd_clr = 3'h0;
		if (s_axi_arvalid && !s_reg.rvalid && rd_sel == lps_pkg::SEL_IRQ_STATUS) begin
			irq_rd_clr = 3'h7;
		end
	end

	always_comb begin
		s_next = s_reg;

		// flags: a new event wins over a clear in the same cycle
		s_next.fault = ((s_reg.fault & ~fault_clr) | fault_set) &
			((8'h01 << lps_pkg::BIT_OVERTEMP) | (8'h01 << lps_pkg::BIT_HF) |
			(8'h01 << lps_pkg::BIT_UV));
		s_next.irq_status = (s_reg.irq_status & ~irq_rd_clr) | irq_set;

		// write address and data are taken independently
		if (s_axi_awvalid && !s_reg.aw_held && !s_reg.bvalid) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_held && !s_reg.bvalid) begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (wr_commit) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = lps_pkg::RESP_OKAY;
			if (wr_sel == lps_pkg::SEL_CONTROL) begin
				s_next.control = wbyte & lps_pkg::CONTROL_WMASK;
			end else if (wr_sel == lps_pkg::SEL_TX_ROUTE) begin
				s_next.tx_route = wbyte[1:0];
			end else if (wr_sel == lps_pkg::SEL_RX_ROUTE) begin
				s_next.rx_route = wbyte[1:0];
			end else if (wr_sel == lps_pkg::SEL_IRQ_MASK) begin
				s_next.irq_mask = wbyte[2:0];
			end else if (wr_sel == lps_pkg::SEL_NONE) begin
				s_next.bresp = lps_pkg::RESP_SLVERR;
			end
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// read: data registered one cycle after the address is taken
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_reg.rvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = lps_pkg::RESP_OKAY;
			s_next.rdata = 32'h0000_0000;
			case (rd_sel)
				lps_pkg::SEL_CONTROL: begin
					s_next.rdata[7:0] = s_reg.control;
				end
				lps_pkg::SEL_FAULT: begin
					s_next.rdata[7:0] = s_reg.fault;
				end
				lps_pkg::SEL_LIVE: begin
					s_next.rdata[7:0] = live_status;
				end
				lps_pkg::SEL_TX_ROUTE: begin
					s_next.rdata[1:0] = s_reg.tx_route;
				end
				lps_pkg::SEL_RX_ROUTE: begin
					s_next.rdata[1:0] = s_reg.rx_route;
				end
				lps_pkg::SEL_IRQ_STATUS: begin
					// events in the read cycle stay pending for the next read
					s_next.rdata[2:0] = s_reg.irq_status;
				end
				lps_pkg::SEL_IRQ_MASK: begin
					s_next.rdata[2:0] = s_reg.irq_mask;
				end
				default: begin
					s_next.rresp = lps_pkg::RESP_SLVERR;
				end
			endcase
		end

		// registered line outputs from the multiplexer
		s_next.lin_txd = rt.lin_txd_next;
		s_next.uart_rxd = rt.uart_rxd_next;
		s_next.port_b_rxd = rt.port_b_rxd_next;
		s_next.irq = |(s_next.irq_status & s_next.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.fault <= lps_pkg::RST_FAULT;
			s_reg.tx_route <= lps_pkg::RST_ROUTE;
			s_reg.rx_route <= lps_pkg::RST_ROUTE;
			s_reg.control <= lps_pkg::RST_CONTROL;
			s_reg.irq_status <= lps_pkg::RST_IRQ;
			s_reg.irq_mask <= lps_pkg::RST_IRQ;
			s_reg.lin_txd <= lps_pkg::LEVEL_RECESSIVE;
			s_reg.uart_rxd <= lps_pkg::LEVEL_RECESSIVE;
			s_reg.port_b_rxd <= lps_pkg::LEVEL_RECESSIVE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign lin_txd = s_reg.lin_txd;
	assign uart_rxd = s_reg.uart_rxd;
	assign port_b_rxd = s_reg.port_b_rxd;
	assign irq = s_reg.irq;
endmodule

// file: test/lps_xcvr_model.sv
// bus side of the transceiver: the lin wire and one other node on it
// assumes the aclk domain; 0 on lin_txd and lin_rxd is dominant
module lps_xcvr_model (
	// clock
	input wire logic aclk,
	// transceiver side
	input wire logic lin_txd,
	input wire logic other_dom,
	output logic lin_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	// wired-and bus: any node pulling low wins, echo comes one cycle late
	always_ff @(posedge aclk) lin_rxd <= lin_txd & ~other_dom;
endmodule

// file: test/lps_top_chk.sv
// concurrent checks on the ports of lps_top
// assumes one aclk domain with synchronous active-low aresetn
module lps_top_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line side
	input wire logic lin_rxd,
	input wire logic lin_txd,
	input wire logic uart_rxd,
	input wire logic port_b_rxd,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// receive level takes two sync stages plus the output register
	property p_rx_uart;
		!uart_rxd |-> !$past(lin_rxd, 2) || !$past(lin_rxd, 3) || !$past(lin_rxd, 4);
	endproperty
	property p_rx_port_b;
		!port_b_rxd |-> !$past(lin_rxd, 2) || !$past(lin_rxd, 3) || !$past(lin_rxd, 4);
	endproperty
	property p_reset_idle;
		$rose(aresetn) |-> lin_txd && uart_rxd && port_b_rxd && !irq && !s_axi_bvalid;
	endproperty
	property p_wr_answer;
		s_wr_taken |-> ##[1:3] s_axi_bvalid;
	endproperty
	property p_wr_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rd_answer;
		s_rd_taken |-> ##[1:2] s_axi_rvalid;
	endproperty
	property p_rd_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_rd_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rx_uart: assert property (p_rx_uart)
		else $error("uart receive dominant without bus");
	a_rx_port_b: assert property (p_rx_port_b)
		else $error("port b receive dominant without bus");
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response late");
	a_wr_refuse: assert property (p_wr_refuse)
		else $error("write accepted while response pending");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read data late");
	a_rd_refuse: assert property (p_rd_refuse)
		else $error("read accepted while data pending");
	a_rd_done: assert property (p_rd_done)
		else $error("read data held after handshake");
endmodule

bind lps_top lps_top_chk u_lps_top_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .lin_rxd, .lin_txd, .uart_rxd, .port_b_rxd, .irq);

// file: test/lps_top_tb_top.sv
// self-checking bench for lps_top with an axi4-lite master and a bus model
// assumes the design answers within a few cycles; a watchdog cuts hangs
module lps_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
		$display("BAD %s exp %h got %h", n, e, a); end end
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, lin_rxd, lin_txd, uart_rxd, port_b_rxd, irq, other_dom = 0;
	logic overtemp_detect = 0, hf_disturb_detect = 0, undervoltage_detect = 0;
	logic tx_ready = 0, uart_txd = 1, port_b_txd = 1, d, bus;
	logic [7:0] rd_d;
	logic [31:0] seed = 32'd70;
	logic [31:0] v;
	int error_cnt = 0;
	int checked = 0;

	lps_top u_lps_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .overtemp_detect, .hf_disturb_detect, .undervoltage_detect,
		.tx_ready, .lin_rxd, .lin_txd, .uart_txd, .uart_rxd, .port_b_txd, .port_b_rxd, .irq);
	lps_xcvr_model u_lps_xcvr_model (.aclk, .lin_txd, .other_dom, .lin_rxd);

	always #20 aclk = ~aclk;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction
	// uart wins over port b; force is ORed on top
	function automatic logic dom(input logic [1:0] r, input logic f, u, p);
		return f | (r[0] ? !u : (r[1] ? !p : 1'b0));
	endfunction

	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		@(posedge aclk);
		s_axi_awaddr <= ad(idx);
		s_axi_wdata <= {24'h0, dat};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd_d = s_axi_rdata[7:0];
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
		rd(ad(idx));
		`CHK("rresp", lps_pkg::RESP_OKAY, rd_r)
		`CHK("reg", e, rd_d)
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic pulse(input logic [2:0] f);
		@(posedge aclk);
		{overtemp_detect, hf_disturb_detect, undervoltage_detect} <= f;
		repeat (5) @(posedge aclk);
		{overtemp_detect, hf_disturb_detect, undervoltage_detect} <= 3'h0;
		repeat (4) @(posedge aclk);
	endtask

	initial begin
		#400us;
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk_rd(lps_pkg::IDX_TX_ROUTE, 8'h00);
		chk_rd(lps_pkg::IDX_RX_ROUTE, 8'h00);
		chk_rd(lps_pkg::IDX_FAULT, 8'h00);
		rd(12'h3FC);
		`CHK("slverr", lps_pkg::RESP_SLVERR, rd_r)
		wr(lps_pkg::IDX_RX_ROUTE, 8'hFF);
		`CHK("bresp", lps_pkg::RESP_OKAY, wr_r)
		wr(8'hFF, 8'h01);
		`CHK("bresp", lps_pkg::RESP_SLVERR, wr_r)
		chk_rd(lps_pkg::IDX_RX_ROUTE, 8'h03);
		for (int i = 0; i < 16; i++) begin
			wr(lps_pkg::IDX_TX_ROUTE, {6'h0, i[1:0]});
			wr(lps_pkg::IDX_CONTROL, {3'h0, i[2], 4'h0});
			wr(lps_pkg::IDX_RX_ROUTE, 8'h00);
			tx_ready <= i[3];
			for (int j = 0; j < 4; j++) begin
				v = xs();
				uart_txd <= v[0];
				port_b_txd <= v[1];
				repeat (3) @(posedge aclk);
				d = dom(i[1:0], i[2], v[0], v[1]);
				`CHK("lin_txd", !d, lin_txd)
			end
			chk_rd(lps_pkg::IDX_LIVE, {i[3], 5'h0, d, d});
		end
		wr(lps_pkg::IDX_TX_ROUTE, 8'h00);
		wr(lps_pkg::IDX_CONTROL, 8'h00);
		for (int i = 0; i < 8; i++) begin
			// all four rx route settings, with the other node first recessive, then dominant
			wr(lps_pkg::IDX_RX_ROUTE, {6'h0, i[1:0]});
			other_dom <= i[2];
			bus = !i[2];
			repeat (6) @(posedge aclk);
			`CHK("uart_rxd", i[0] ? bus : 1'b1, uart_rxd)
			`CHK("port_b_rxd", i[1] ? bus : 1'b1, port_b_rxd)
			chk_rd(lps_pkg::IDX_LIVE, {1'b1, 5'h0, !bus, 1'b0});
		end
		other_dom <= 1'b0;
		wr(lps_pkg::IDX_IRQ_MASK, 8'h07);
		wr(lps_pkg::IDX_CONTROL, 8'h80);
		wr(lps_pkg::IDX_TX_ROUTE, 8'h01);
		uart_txd <= 1'b0;
		@(posedge aclk);
		overtemp_detect <= 1'b1;
		hf_disturb_detect <= 1'b1;
		undervoltage_detect <= 1'b1;
		repeat (5) @(posedge aclk);
		`CHK("lin_txd", 1'b1, lin_txd)
		wr(lps_pkg::IDX_CONTROL, 8'h89);
		chk_rd(lps_pkg::IDX_CONTROL, 8'h88);
		`CHK("lin_txd", 1'b0, lin_txd)
		pulse(3'h0);
		uart_txd <= 1'b1;
		chk_rd(lps_pkg::IDX_FAULT, 8'hA8);
		`CHK("irq", 1'b1, irq)
		wr(lps_pkg::IDX_FAULT, 8'h00);
		chk_rd(lps_pkg::IDX_FAULT, 8'hA8);
		wr(lps_pkg::IDX_FAULT, 8'h80);
		chk_rd(lps_pkg::IDX_FAULT, 8'h28);
		wr(lps_pkg::IDX_FAULT, 8'h28);
		chk_rd(lps_pkg::IDX_FAULT, 8'h00);
		chk_rd(lps_pkg::IDX_IRQ_STATUS, 8'h07);
		repeat (2) @(posedge aclk);
		`CHK("irq", 1'b0, irq)
		wr(lps_pkg::IDX_CONTROL, 8'h00);
		wr(lps_pkg::IDX_IRQ_MASK, 8'h00);
		pulse(3'h6);
		chk_rd(lps_pkg::IDX_FAULT, 8'hA0);
		`CHK("irq", 1'b0, irq)
		wr(lps_pkg::IDX_IRQ_MASK, 8'h07);
		repeat (2) @(posedge aclk);
		`CHK("irq", 1'b1, irq)
		chk_rd(lps_pkg::IDX_IRQ_STATUS, 8'h02);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk_rd(lps_pkg::IDX_LIVE, 8'h00);
		chk_rd(lps_pkg::IDX_TX_ROUTE, 8'h00);
		chk_rd(lps_pkg::IDX_RX_ROUTE, 8'h00);
		chk_rd(lps_pkg::IDX_FAULT, 8'h00);
		`CHK("irq", 1'b0, irq)
		print_verdict();
	end
endmodule
